// ===== rtl/emb_mem_consts.svh
// Constants for the configurable embedded memory block
// Functional notes
// R1: The memory supports five shapes, 128x16, 256x8, 512x4, 1024x2 and 2048x1, chosen by configuration.
// R2: Writes use an internal write pulse timed by the clock, so user logic only meets clock setup and hold.
// R3: The low eleven address bits address the block and the upper bits go to a page decoder.
// R4: Only the block whose page matches drives the shared column line; all others keep their drivers off.
// R5: Wider words come from blocks run in parallel on one address with no extra control.
// R6: Two dual-port modes exist: read/write clocking and input/output clocking.
// R7: True two-port read and write use two or four blocks together.
// R8: Six paths each have a selectable register: write data, read data, read address, write address, write and read strobes.
// R9: Input-side and output-side registers may run from different clock enables.
// R10: The block takes a clock, a clock enable and an asynchronous clear, and the strobes come from general routing.
// R11: Each macrocell register acts as D, T, JK or SR, or is bypassed to a combinational output.
// R12: Each macrocell register uses one of two block-wide clocks with that clock's own enable.
// R13: Logic using both clock edges takes both block-wide clocks, one for each edge.
// R14: Ten outputs, nine distinct, feed back to the local routing.
// R15: With a registered read address, read data appear after the next read-side edge with the read strobe high.
`ifndef EMB_MEM_CONSTS_SVH
`define EMB_MEM_CONSTS_SVH
`define MEM_BITS        2048
`define MEM_AW          11
`define MEM_DW          16
`define PAGE_W          2
`define SHAPE_W         3
`define SHAPE_128X16    3'h0
`define SHAPE_256X8     3'h1
`define SHAPE_512X4     3'h2
`define SHAPE_1024X2    3'h3
`define SHAPE_2048X1    3'h4
`define REG_WDATA       0
`define REG_RDATA       1
`define REG_RADDR       2
`define REG_WADDR       3
`define REG_WSTB        4
`define REG_RSTB        5
`define NUM_PATH_REGS   6
`define NUM_MCELL       4
`define LOCAL_FB_W      10
`endif

// ===== rtl/emb_mem_pkg.sv
// Types for the configurable embedded memory block
package emb_mem_pkg;
   typedef enum logic [1:0] {
      FF_D  = 2'b00,
      FF_T  = 2'b01,
      FF_JK = 2'b10,
      FF_SR = 2'b11
   } ff_kind_t;
   typedef enum logic [1:0] {
      PORT_SINGLE = 2'b00,
      PORT_RW_CLK = 2'b01,
      PORT_IO_CLK = 2'b10
   } port_mode_t;
endpackage

// ===== rtl/bit_ram_if.sv
// Carrier between the memory block and its bit array
`timescale 1ns/100ps
interface bit_ram_if;
   logic        we;
   logic [10:0] waddr;
   logic        wbit;
   logic        re;
   logic [10:0] raddr;
   logic [15:0] rword;
   modport ctrl (output we, waddr, wbit, re, raddr, input rword);
   modport mem  (input we, waddr, wbit, re, raddr, output rword);
endinterface

// ===== rtl/bit_ram.sv
// Bit array of one memory block with registered read word
`timescale 1ns/100ps
`include "emb_mem_consts.svh"
module bit_ram
(
   input  wire logic sys_clk,   // Core clock
   bit_ram_if.mem    port       // Array access
);
   logic [`MEM_BITS-1:0] cells;

   // ******************************
   // Array write, single bit
   // ******************************
   always_ff @(posedge sys_clk)
   begin
      if (port.we)
         cells[port.waddr] <= port.wbit;
   end

   // ******************************
   // Read: sixteen bits starting at raddr
   // ******************************
   genvar i;
   generate
      for (i = 0; i < `MEM_DW; i++)
      begin : g_rd
         always_ff @(posedge sys_clk)
         begin
            if (port.re)
               port.rword[i] <= cells[(port.raddr + 11'(i)) & 11'h7ff];
         end
      end
   endgenerate
endmodule

// ===== rtl/emb_mem_block.sv
// Configurable embedded memory block with macrocell registers
`timescale 1ns/100ps
`include "emb_mem_consts.svh"
module emb_mem_block
(
   input  wire logic                    sys_clk,       // Core clock, 100 MHz
   input  wire logic                    rst,           // Asynchronous clear, active high
   input  wire logic [`SHAPE_W-1:0]     shape,         // Aspect ratio selector
   input  wire emb_mem_pkg::port_mode_t port_mode,     // Dual-port clocking mode
   input  wire logic [`NUM_PATH_REGS-1:0] path_reg_en, // Per-path register select
   input  wire logic                    in_ce,         // Input-side clock enable
   input  wire logic                    out_ce,        // Output-side clock enable
   input  wire logic                    mem_write_strobe, // Write strobe
   input  wire logic                    mem_read_strobe,  // Read strobe
   input  wire logic [12:0]             waddr,         // Write address incl. page
   input  wire logic [12:0]             raddr,         // Read address incl. page
   input  wire logic [15:0]             wdata,         // Write data
   input  wire logic [`PAGE_W-1:0]      page_id,       // This block's page
   output      logic [15:0]             rdata,         // Read data
   output      logic [15:0]             col_out,       // Column line drive value
   output      logic                    col_oe,        // Column driver enable
   input  wire emb_mem_pkg::ff_kind_t [`NUM_MCELL-1:0] mc_kind, // Macrocell type
   input  wire logic [`NUM_MCELL-1:0]   mc_bypass,     // Macrocell bypass
   input  wire logic [`NUM_MCELL-1:0]   mc_clk_sel,    // Block-wide clock select
   input  wire logic [`NUM_MCELL-1:0]   mc_a,          // D, T, J or S input
   input  wire logic [`NUM_MCELL-1:0]   mc_b,          // K or R input
   input  wire logic [1:0]              mc_ce,         // Enable per block-wide clock
   input  wire logic                    mc_use_fall,   // Clock 1 acts on falling phase
   output      logic [`NUM_MCELL-1:0]   mc_out,        // Macrocell outputs
   output      logic [`LOCAL_FB_W-1:0]  local_fb       // Feedback to local routing
);
   import emb_mem_pkg::*;

   bit_ram_if ram();
   bit_ram u_ram
   (
      .sys_clk (sys_clk),
      .port    (ram)
   );

   // ******************************
   // Shape decode
   // ******************************
   logic [4:0]  wbits;
   logic [3:0]  lsh;
   // R1 five aspect ratios
   always_comb
   begin
      unique case (shape)
         `SHAPE_128X16: begin wbits = 5'h10; lsh = 4'h4; end
         `SHAPE_256X8:  begin wbits = 5'h08; lsh = 4'h3; end
         `SHAPE_512X4:  begin wbits = 5'h04; lsh = 4'h2; end
         `SHAPE_1024X2: begin wbits = 5'h02; lsh = 4'h1; end
         default:       begin wbits = 5'h01; lsh = 4'h0; end
      endcase
   end

   // ******************************
   // Path registers
   // ******************************
   logic [15:0] wdata_q;
   logic [12:0] waddr_q;
   logic [12:0] raddr_q;
   logic        wstb_q;
   logic        rstb_q;
   logic        rd_ce;
   logic        wr_ce;
   // R6 dual-port clocking
   // R9 separate in/out enables
   assign wr_ce = in_ce;
   assign rd_ce = (port_mode == PORT_SINGLE) ? in_ce : out_ce;

   // R8 selectable path registers
   // R10 clear and enable
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wdata_q <= 16'h0000;
         waddr_q <= 13'h0000;
         wstb_q  <= 1'b0;
      end
      else if (wr_ce)
      begin
         wdata_q <= wdata;
         waddr_q <= waddr;
         wstb_q  <= mem_write_strobe;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         raddr_q <= 13'h0000;
         rstb_q  <= 1'b0;
      end
      else if (rd_ce)
      begin
         raddr_q <= raddr;
         rstb_q  <= mem_read_strobe;
      end
   end

   logic [15:0] wd;
   logic [12:0] wa;
   logic [12:0] ra;
   logic        ws;
   logic        rs;
   assign wd = path_reg_en[`REG_WDATA] ? wdata_q : wdata;
   assign wa = path_reg_en[`REG_WADDR] ? waddr_q : waddr;
   assign ra = path_reg_en[`REG_RADDR] ? raddr_q : raddr;
   assign ws = path_reg_en[`REG_WSTB]  ? wstb_q  : mem_write_strobe;
   assign rs = path_reg_en[`REG_RSTB]  ? rstb_q  : mem_read_strobe;

   // ******************************
   // Self-timed write sequencer
   // ******************************
   // Wide shapes are written bit-serially, so user logic never times a pulse itself
   logic        wr_busy;
   logic [3:0]  wr_cnt;
   logic [15:0] wr_word;
   logic [10:0] wr_base;
   logic [3:0]  wr_last;
   logic        wr_hit;
   // R3 page select on upper bits
   assign wr_hit = (wa[12:11] == page_id);

   // R2 internal write pulse
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_busy <= 1'b0;
         wr_cnt  <= 4'h0;
         wr_word <= 16'h0000;
         wr_base <= 11'h000;
         wr_last <= 4'h0;
      end
      else if (!wr_busy)
      begin
         if (ws && wr_ce && wr_hit)
         begin
            wr_busy <= 1'b1;
            wr_cnt  <= 4'h0;
            wr_word <= wd;
            wr_base <= 11'((wa[10:0] << lsh) & 11'h7ff);
            wr_last <= 4'(wbits - 5'h01);
         end
      end
      else
      begin
         wr_cnt <= wr_cnt + 4'h1;
         if (wr_cnt == wr_last)
            wr_busy <= 1'b0;
      end
   end

   assign ram.we    = wr_busy;
   assign ram.waddr = wr_base + 11'(wr_cnt);
   assign ram.wbit  = wr_word[wr_cnt];

   // ******************************
   // Read path
   // ******************************
   logic       rd_hit;
   logic       rd_vld;
   logic [1:0] rd_page;
   logic [3:0] rd_lsh;
   assign rd_hit    = (ra[12:11] == page_id);
   assign ram.re    = rs && rd_ce;
   assign ram.raddr = 11'((ra[10:0] << lsh) & 11'h7ff);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_vld  <= 1'b0;
         rd_page <= 2'h0;
         rd_lsh  <= 4'h0;
      end
      else if (rs && rd_ce)
      begin
         rd_vld  <= 1'b1;
         rd_page <= ra[12:11];
         rd_lsh  <= lsh;
      end
   end

   logic [15:0] rd_mask;
   logic [15:0] rd_word;
   assign rd_mask = 16'((17'h0_0001 << (5'h01 << rd_lsh)) - 17'h0_0001);
   // Nothing read since the clear shows zero, not whatever the array output still holds
   assign rd_word = rd_vld ? (ram.rword & rd_mask) : 16'h0000;

   logic [15:0] rdata_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= 16'h0000;
      else if (out_ce)
         rdata_q <= rd_word;
   end

   // R15 read latency
   // R5 parallel blocks share address
   assign rdata = path_reg_en[`REG_RDATA] ? rdata_q : rd_word;

   // ******************************
   // Page-decoded column driver
   // ******************************
   // R4 only matching page drives
   // R7 paired blocks share this decode
   assign col_oe  = rd_vld && (rd_page == page_id) && !rst;
   assign col_out = rdata;

   // ******************************
   // Macrocell registers
   // ******************************
   logic [1:0] clk_act;
   logic       phase;
   // Falling edge emulated by an alternating phase enable on the single core clock
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         phase <= 1'b0;
      else
         phase <= ~phase;
   end
   // R13 both clocks for two edges
   assign clk_act[0] = mc_ce[0] && (!mc_use_fall || !phase);
   assign clk_act[1] = mc_ce[1] && (!mc_use_fall || phase);

   logic [`NUM_MCELL-1:0] mc_q;
   genvar m;
   generate
      for (m = 0; m < `NUM_MCELL; m++)
      begin : g_mc
         logic next_q;
         // R11 D T JK SR
         always_comb
         begin
            unique case (mc_kind[m])
               FF_D:  next_q = mc_a[m];
               FF_T:  next_q = mc_q[m] ^ mc_a[m];
               FF_JK: next_q = (mc_a[m] & ~mc_q[m]) | (~mc_b[m] & mc_q[m]);
               FF_SR: next_q = mc_a[m] | (~mc_b[m] & mc_q[m]);
            endcase
         end
         // R12 clock with own enable
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
               mc_q[m] <= 1'b0;
            else if (clk_act[mc_clk_sel[m]])
               mc_q[m] <= next_q;
         end
         assign mc_out[m] = mc_bypass[m] ? mc_a[m] : mc_q[m];
      end
   endgenerate

   // R14 ten feedback lines, nine distinct
   assign local_fb = {rdata[7:0], rdata[0], col_oe};
endmodule

// ===== verif/emb_mem_block_monitor.sv
// Port checker for the embedded memory block
`timescale 1ns/100ps
module emb_mem_block_monitor
(
   input wire logic                        sys_clk,         // Clock
   input wire logic                        rst,             // Clear
   input wire logic [2:0]                  shape,           // Shape
   input wire logic [5:0]                  path_reg_en,     // Stages
   input wire logic                        in_ce,           // In enable
   input wire logic                        out_ce,          // Out enable
   input wire logic                        mem_read_strobe, // Read
   input wire logic [12:0]                 raddr,           // Read address
   input wire logic [1:0]                  page_id,         // Page
   input wire logic [15:0]                 rdata,           // Data
   input wire logic                        col_oe,          // Driver on
   input wire emb_mem_pkg::ff_kind_t [3:0] mc_kind,         // Cell kind
   input wire logic [3:0]                  mc_bypass,       // Bypass
   input wire logic [3:0]                  mc_clk_sel,      // Clock pick
   input wire logic [3:0]                  mc_a,            // D/T/J/S
   input wire logic [1:0]                  mc_ce,           // Enables
   input wire logic                        mc_use_fall,     // Split phase
   input wire logic [3:0]                  mc_out,          // Cells
   input wire logic [9:0]                  local_fb         // Feedback
);
   import emb_mem_pkg::*;
   logic rd;
   // Both enables high, so the check holds whichever one the mode picks
   assign rd = mem_read_strobe && in_ce && out_ce && path_reg_en == 6'h00;
   // ****************
   // Assertions
   // ****************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   chk_oe_page: assert property (rd |=> col_oe == ($past(raddr[12:11]) == $past(page_id)))
      else $error("column driver does not follow page match");
   chk_fb_map: assert property (local_fb == {rdata[7:0], rdata[0], col_oe})
      else $error("local feedback map wrong");
   chk_rdata_hold: assert property ((path_reg_en == 6'h00 && !mem_read_strobe) ##1 ($stable(shape)
         && $stable(path_reg_en)) |-> $stable(rdata))
      else $error("read data moved without a read");
   chk_narrow_zero: assert property (rd && shape == 3'h4 |=> rdata[15:1] == 15'h0000)
      else $error("unused read bits not zero");
   chk_reset_clear: assert property ($fell(rst) |-> rdata == 16'h0000 && !col_oe
         && (mc_out & ~mc_bypass) == 4'h0)
      else $error("state not cleared by reset");
   chk_mc_dflop: assert property ((!mc_bypass[0] && mc_kind[0] == FF_D && !mc_clk_sel[0] && mc_ce[0]
         && !mc_use_fall) ##1 !mc_bypass[0] |-> mc_out[0] == $past(mc_a[0]))
      else $error("D cell did not load");
   chk_mc_toggle: assert property ((!mc_bypass[1] && mc_kind[1] == FF_T && mc_a[1] && mc_clk_sel[1]
         && mc_ce[1] && !mc_use_fall) ##1 !mc_bypass[1] |-> mc_out[1] != $past(mc_out[1]))
      else $error("T cell on clock one did not toggle");
   chk_mc_hold: assert property ((!mc_bypass[2] && !mc_ce[mc_clk_sel[2]]) ##1 !mc_bypass[2]
         |-> $stable(mc_out[2]))
      else $error("cell moved with its enable low");
   chk_mc_bypass: assert property (mc_bypass[3] |-> mc_out[3] == mc_a[3])
      else $error("bypassed cell not combinational");
endmodule
bind emb_mem_block emb_mem_block_monitor i_mon
(
   .sys_clk(sys_clk), .rst(rst), .shape(shape), .path_reg_en(path_reg_en), .in_ce(in_ce),
   .out_ce(out_ce), .mem_read_strobe(mem_read_strobe), .raddr(raddr), .page_id(page_id),
   .rdata(rdata), .col_oe(col_oe), .mc_kind(mc_kind), .mc_bypass(mc_bypass),
   .mc_clk_sel(mc_clk_sel), .mc_a(mc_a), .mc_ce(mc_ce), .mc_use_fall(mc_use_fall),
   .mc_out(mc_out), .local_fb(local_fb)
);

// ===== verif/user_cells.sv
// Model of the user logic cells driving the memory ports
`timescale 1ns/100ps
module user_cells
(
   input  wire logic        sys_clk, // Clock
   output      logic        wr_stb,  // Write strobe
   output      logic        rd_stb,  // Read strobe
   output      logic [12:0] waddr,   // Write address
   output      logic [12:0] raddr,   // Read address
   output      logic [15:0] wdata    // Write data
);
   initial
   begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      waddr = 13'h0000;
      raddr = 13'h0000;
      wdata = 16'h0000;
   end
   // Launch after an edge, hold one cycle, then idle for the bit count
   task automatic write_word(input logic [12:0] a, input logic [15:0] d, input int gap);
      @(posedge sys_clk);
      wr_stb <= 1'b1;
      waddr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      // Released lines show the inverse, never a stale copy
      waddr <= ~a;
      wdata <= ~d;
      repeat (gap) @(posedge sys_clk);
   endtask
   task automatic read_word(input logic [12:0] a);
      @(posedge sys_clk);
      rd_stb <= 1'b1;
      raddr <= a;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      raddr <= ~a;
   endtask
endmodule

// ===== verif/test_emb_mem_block.sv
// Self-checking bench for the embedded memory block
`timescale 1ns/100ps
module test_emb_mem_block;
   import emb_mem_pkg::*;
   logic           sys_clk = 1'b0;
   logic           rst = 1'b1;
   logic [2:0]     shape = 3'h0;
   port_mode_t     port_mode = PORT_SINGLE;
   logic [5:0]     path_reg_en = 6'h00;
   logic [1:0]     page_id = 2'h2;
   ff_kind_t [3:0] mc_kind = {4{FF_D}};
   logic [3:0]     mc_bypass = 4'h0, mc_clk_sel = 4'h0, mc_a = 4'h0, mc_b = 4'h0, mc_out;
   logic [1:0]     mc_ce = 2'h0, pg;
   logic [2:0]     sh = 3'h0;
   logic           in_ce = 1'b1, out_ce = 1'b1;
   logic           mc_use_fall = 1'b0, ws, rs, col_oe;
   logic [12:0]    wa, ra;
   logic [15:0]    wd, rdata, col_out, d;
   logic [9:0]     local_fb;
   logic [10:0]    a;
   logic           bits [0:2047];
   logic [16:0]    expq [$];
   logic [16:0]    exp_v;
   int             fails = 0, checked = 0, lat = 1, s, m, k, w, j;
   emb_mem_block i_dut
   (
      .sys_clk(sys_clk), .rst(rst), .shape(shape), .port_mode(port_mode),
      .path_reg_en(path_reg_en), .in_ce(in_ce), .out_ce(out_ce),
      .mem_write_strobe(ws), .mem_read_strobe(rs), .waddr(wa), .raddr(ra),
      .wdata(wd), .page_id(page_id), .rdata(rdata), .col_out(col_out),
      .col_oe(col_oe), .mc_kind(mc_kind), .mc_bypass(mc_bypass),
      .mc_clk_sel(mc_clk_sel), .mc_a(mc_a), .mc_b(mc_b), .mc_ce(mc_ce),
      .mc_use_fall(mc_use_fall), .mc_out(mc_out), .local_fb(local_fb)
   );
   user_cells i_cells
   (
      .sys_clk(sys_clk), .wr_stb(ws), .rd_stb(rs), .waddr(wa), .raddr(ra), .wdata(wd)
   );
   always #5 sys_clk = ~sys_clk;
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [15:0] get(input logic [10:0] adr, input int n);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < n; i++)
         r[i] = bits[adr * n + i];
      return r;
   endfunction
   // ****************
   // Scoreboard
   // ****************
   always @(posedge sys_clk)
      sh <= {sh[1:0], rs & ~rst & ((port_mode == PORT_SINGLE) ? in_ce : out_ce)};
   always @(negedge sys_clk)
      if (sh[lat - 1])
      begin
         exp_v = expq.pop_front();
         check({col_oe, rdata}, exp_v);
         check({col_oe, col_out}, exp_v);
      end
   // Cells see fresh random inputs every cycle
   always @(posedge sys_clk)
   begin
      for (int i = 0; i < 4; i++)
         mc_kind[i] <= ff_kind_t'(2'($urandom));
      {mc_bypass, mc_clk_sel, mc_a, mc_b} <= 16'($urandom);
      mc_ce <= 2'($urandom);
      mc_use_fall <= ($urandom % 8) == 0;
   end
   // ****************
   // Stimulus
   // ****************
   initial
   begin
      void'($urandom(32'h6c4deef8));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // Last two passes register all six paths
      for (m = 0; m < 6; m++)
      begin
         // Let the last read of the previous pass retire before the latency moves
         repeat (3) @(posedge sys_clk);
         port_mode <= m[0] ? PORT_IO_CLK : PORT_SINGLE;
         path_reg_en <= (m > 3) ? 6'h3f : m[1] ? 6'h02 : 6'h00;
         lat = (m > 3) ? 3 : m[1] ? 2 : 1;
         for (s = 0; s < 5; s++)
         begin
            @(posedge sys_clk);
            shape <= 3'(s);
            w = 16 >> s;
            for (k = 0; k < 3; k++)
            begin
               a = (k == 0) ? 11'((128 << s) - 1) : (k == 1) ? 11'($urandom % (128 << s)) : a;
               d = 16'($urandom);
               pg = (k == 2) ? page_id + 2'h1 : page_id;
               // Only a page hit stores the word
               if (k < 2)
                  for (j = 0; j < w; j++)
                     bits[a * w + j] = d[j];
               i_cells.write_word({pg, a}, d, w);
               expq.push_back({1'b1, get(a, w)});
               i_cells.read_word({page_id, a});
               expq.push_back({1'b0, get(a, w)});
               i_cells.read_word({page_id + 2'h1, a});
            end
         end
      end
      // In input/output mode the read side runs on the output enable only
      repeat (3) @(posedge sys_clk);
      port_mode <= PORT_IO_CLK;
      path_reg_en <= 6'h00;
      in_ce <= 1'b0;
      lat = 1;
      expq.push_back({1'b1, get(a, w)});
      i_cells.read_word({page_id, a});
      @(posedge sys_clk);
      in_ce <= 1'b1;
      out_ce <= 1'b0;
      i_cells.read_word({page_id + 2'h1, a});
      @(negedge sys_clk);
      check({col_oe, rdata}, {1'b1, get(a, w)});
      repeat (3) @(posedge sys_clk);
      out_ce <= 1'b1;
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check({col_oe, rdata}, 17'h0_0000);
      test_done;
   end
   // About 1,200 cycles are needed; 10,000 leaves ample margin
   initial
   begin
      #100000;
      fails++;
      test_done;
   end
endmodule
